/* hw/ecpp_regs.vh */
`ifndef ECPP_REGS_VH
`define ECPP_REGS_VH
`define ECPP_OFS_DATA 11'h000
`define ECPP_OFS_STATUS 11'h001
`define ECPP_OFS_CONTROL 11'h002
`define ECPP_OFS_FIFO 11'h400
`define ECPP_OFS_CFGB 11'h401
`define ECPP_OFS_ECR 11'h402
`define ECPP_MODE_SPP 3'h0
`define ECPP_MODE_BIDIR 3'h1
`define ECPP_MODE_COMPAT_FIFO_WINDOW 3'h2
`define ECPP_MODE_ECP 3'h3
`define ECPP_MODE_EPP 3'h4
`define ECPP_MODE_RSVD 3'h5
`define ECPP_MODE_TEST 3'h6
`define ECPP_MODE_CFG 3'h7
`define ECPP_ECR_MODE_HI 7
`define ECPP_ECR_MODE_LO 5
`define ECPP_CTL_DIR 5
`define ECPP_CFGA_VALUE 8'h10
`define ECPP_CFGB_RESET 8'h07
`define ECPP_ECR_RESET 8'h15
`define ECPP_CTL_RESET 8'hc0
`define ECPP_FIFO_DEPTH 16
`define ECPP_STROBE_NS 500
`define ECPP_CLK_NS 5
`define ECPP_STROBE_CYC ((`ECPP_STROBE_NS + `ECPP_CLK_NS - 1) / `ECPP_CLK_NS)
`endif

/* hw/ecpp_fifo.v */
`timescale 1ns/10ps
`include "ecpp_regs.vh"
module ecpp_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = `ECPP_FIFO_DEPTH,
  parameter AW = 4
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_flush,
  input wire i_push,
  input wire [WIDTH-1:0] i_wdata,
  input wire i_pop,
  output wire [WIDTH-1:0] o_rdata,
  output wire o_full,
  output wire o_empty
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wp_r;
  reg [AW:0] rp_r;
  wire do_push = i_push && !o_full;
  wire do_pop = i_pop && !o_empty;
  assign o_empty = (wp_r == rp_r);
  assign o_full = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
  assign o_rdata = mem[rp_r[AW-1:0]];
  always @(posedge i_clk) begin
    if (do_push) begin
      mem[wp_r[AW-1:0]] <= i_wdata;
    end
  end
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
    end else if (i_flush) begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (do_pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule

/* hw/ecpp_core.v */
`timescale 1ns/10ps
`include "ecpp_regs.vh"
// Notes on behaviour
// - one shared sixteen-byte fifo serves every fifo window, both directions.
// - ecp mode moves data by dma forward and reverse.
// - compatible fifo mode handshakes bytes out automatically, no software strobe.
// - received run-length count byte repeats the following byte count+1 times.
// - mode comes from extended control bits 7 to 5.
// - mode codes: spp, bidir, compat_fifo_window, ecp, epp, reserved, test, config.
// - epp mode 100 only works when combined ecp/epp option enabled.
// - offset 400h maps compat_fifo_window, ecp data, test fifo or config a by mode.
// - config b at 401h in mode 111 only; ecr at 402h always.
// - config a reads fixed 10h in mode 111, read only.
// - modes 000/001 data write drives lines; read returns line levels.
// - mode 011 write to offset 0 queues tagged byte, forward only.
// - address/rle byte bit 7 selects address versus count; low seven carry value.
// - status bit 7 is inverted busy input.
// - status bits 6..3 are ack, paper error, select, fault unchanged.
// - status bits 2..0 always read one.
// - direction bit ignored in modes 000 and 010; else one means input.
// - mode 010 sends fifo bytes with standard handshake, forward only.
module ecpp_core #(
  parameter STROBE_CYC = `ECPP_STROBE_CYC
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire [10:0] i_addr,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  input wire i_epp_option_en,
  input wire i_dma_ack,
  output wire o_dma_req,
  input wire [7:0] i_port_data_lines,
  output wire [7:0] o_port_data_lines,
  output wire o_port_data_lines_oe_n,
  output wire o_strobe_n,
  output wire o_autofd_n,
  output wire o_init_n,
  output wire o_select_in_n,
  input wire i_busy,
  input wire i_acknowledge_n,
  input wire i_paper_error,
  input wire i_select,
  input wire i_fault_n
);
  localparam ST_IDLE = 2'd0;
  localparam ST_SETUP = 2'd1;
  localparam ST_STROBE = 2'd2;
  localparam ST_WAIT = 2'd3;
  localparam [15:0] STB_CYC = STROBE_CYC;
  localparam [7:0] CTL_RST = `ECPP_CTL_RESET;
  localparam [7:0] CFGB_RST = `ECPP_CFGB_RESET;

  reg [7:0] pd_s1_r, pd_s2_r;
  reg [4:0] st_s1_r, st_s2_r;
  reg [7:0] data_r;
  reg [5:0] ctl_r;
  reg [7:0] ecr_r;
  reg [2:0] cfgb_r;
  reg [7:0] out_r;
  reg [1:0] st_r, st_nxt;
  reg [15:0] cnt_r;
  reg stb_r;
  reg [6:0] rle_r;
  reg out_tag_r;
  reg rd_pend_r;
  reg [7:0] rd_byte_r;
  reg [1:0] rd_st_r;

  wire [2:0] mode = ecr_r[`ECPP_ECR_MODE_HI:`ECPP_ECR_MODE_LO];
  wire busy_s = st_s2_r[4];
  wire ack_n_s = st_s2_r[3];
  wire mode_spp = (mode == `ECPP_MODE_SPP);
  wire mode_bidir = (mode == `ECPP_MODE_BIDIR);
  wire mode_cf = (mode == `ECPP_MODE_COMPAT_FIFO_WINDOW);
  wire mode_ecp = (mode == `ECPP_MODE_ECP);
  wire mode_epp = (mode == `ECPP_MODE_EPP) && i_epp_option_en;
  wire mode_test = (mode == `ECPP_MODE_TEST);
  wire mode_cfg = (mode == `ECPP_MODE_CFG);
  // direction only honoured where the mode can turn the bus round
  wire dir_in = (mode_spp || mode_cf) ? 1'b0 : ctl_r[`ECPP_CTL_DIR];
  wire fifo_win = mode_cf || mode_ecp || mode_test;
  wire fwd_fifo = (mode_cf || mode_ecp) && !dir_in;

  wire f_full, f_empty;
  wire [8:0] f_head;
  reg f_push;
  reg [8:0] f_wdata;
  wire f_pop;

  function hit;
    input [10:0] a;
    input [10:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  wire w_data = i_wr && hit(i_addr, `ECPP_OFS_DATA);
  wire w_fifo = i_wr && hit(i_addr, `ECPP_OFS_FIFO);
  wire r_fifo = i_rd && hit(i_addr, `ECPP_OFS_FIFO) && fifo_win;
  wire dma_wr = i_dma_ack && fwd_fifo;
  wire dma_rd = i_dma_ack && mode_ecp && dir_in;
  wire mode_chg = i_wr && hit(i_addr, `ECPP_OFS_ECR) && (i_wdata[7:5] != mode);

  // pushes from host writes, dma and reverse receive share one port
  always @* begin
    f_push = 1'b0;
    f_wdata = {1'b0, i_wdata};
    if (w_fifo && fifo_win && (fwd_fifo || mode_test)) begin
      f_push = 1'b1;
    end else if (w_data && mode_ecp && !dir_in) begin
      f_push = 1'b1;
      f_wdata = {1'b1, i_wdata};
    end else if (dma_wr) begin
      f_push = 1'b1;
    end else if (rd_pend_r) begin
      f_push = 1'b1;
      f_wdata = {1'b0, rd_byte_r};
    end
  end

  wire host_pop = (r_fifo && !fwd_fifo) || dma_rd;
  wire tx_pop = (st_r == ST_IDLE) && fwd_fifo && !f_empty;
  assign f_pop = host_pop || tx_pop;
  assign o_dma_req = (fwd_fifo && !f_full) || (mode_ecp && dir_in && !f_empty);

  ecpp_fifo #(.WIDTH(9), .DEPTH(`ECPP_FIFO_DEPTH), .AW(4)) u_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_flush(mode_chg),
    .i_push(f_push),
    .i_wdata(f_wdata),
    .i_pop(f_pop),
    .o_rdata(f_head),
    .o_full(f_full),
    .o_empty(f_empty)
  );

  // pins come from outside the clock domain
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pd_s1_r <= 8'h00;
      pd_s2_r <= 8'h00;
      st_s1_r <= 5'h00;
      st_s2_r <= 5'h00;
    end else begin
      pd_s1_r <= i_port_data_lines;
      pd_s2_r <= pd_s1_r;
      st_s1_r <= {i_busy, i_acknowledge_n, i_paper_error, i_select, i_fault_n};
      st_s2_r <= st_s1_r;
    end
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      data_r <= 8'h00;
      ctl_r <= CTL_RST[5:0];
      ecr_r <= `ECPP_ECR_RESET;
      cfgb_r <= CFGB_RST[2:0];
    end else begin
      if (w_data && (mode_spp || mode_bidir)) begin
        data_r <= i_wdata;
      end
      if (i_wr && hit(i_addr, `ECPP_OFS_CONTROL)) begin
        ctl_r <= i_wdata[5:0];
      end
      if (i_wr && hit(i_addr, `ECPP_OFS_ECR)) begin
        ecr_r[7:3] <= i_wdata[7:3];
      end
      ecr_r[1] <= f_full;
      ecr_r[0] <= f_empty;
      if (i_wr && hit(i_addr, `ECPP_OFS_CFGB) && mode_cfg) begin
        cfgb_r <= i_wdata[2:0];
      end
    end
  end

  // forward handshake: setup, strobe pulse, wait for busy low
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (tx_pop) begin
          st_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_r == 16'h0000 && !busy_s) begin
          st_nxt = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (cnt_r == 16'h0000) begin
          st_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cnt_r == 16'h0000 && !busy_s) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r <= ST_IDLE;
      cnt_r <= 16'h0000;
      stb_r <= 1'b0;
      out_r <= 8'h00;
      out_tag_r <= 1'b0;
    end else if (mode_chg || !fwd_fifo) begin
      st_r <= ST_IDLE;
      stb_r <= 1'b0;
      cnt_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      if (st_r != st_nxt) begin
        cnt_r <= STB_CYC - 16'h0001;
      end else if (cnt_r != 16'h0000) begin
        cnt_r <= cnt_r - 16'h0001;
      end
      stb_r <= (st_nxt == ST_STROBE);
      if (tx_pop) begin
        out_r <= f_head[7:0];
        // tag rides with the byte; fifo head has moved on by strobe time
        out_tag_r <= f_head[8];
      end
    end
  end

  // reverse ecp receive with rle expansion: ack low latches a byte
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_st_r <= 2'd0;
      rd_pend_r <= 1'b0;
      rd_byte_r <= 8'h00;
      rle_r <= 7'h00;
    end else if (!(mode_ecp && dir_in)) begin
      rd_st_r <= 2'd0;
      rd_pend_r <= 1'b0;
      rle_r <= 7'h00;
    end else begin
      rd_pend_r <= 1'b0;
      case (rd_st_r)
        2'd0: begin
          if (!ack_n_s && !f_full) begin
            // busy high marks a command byte; bit 7 clear there means count
            if (busy_s && !pd_s2_r[7]) begin
              rle_r <= pd_s2_r[6:0];
              rd_st_r <= 2'd2;
            end else begin
              rd_byte_r <= pd_s2_r;
              rd_pend_r <= 1'b1;
              rd_st_r <= (rle_r != 7'h00) ? 2'd1 : 2'd2;
            end
          end
        end
        2'd1: begin
          if (rle_r == 7'h00) begin
            rd_st_r <= 2'd2;
          end else if (!f_full && !rd_pend_r) begin
            rd_pend_r <= 1'b1;
            rle_r <= rle_r - 7'h01;
          end
        end
        2'd2: begin
          if (ack_n_s) begin
            rd_st_r <= 2'd0;
          end
        end
        default: rd_st_r <= 2'd0;
      endcase
    end
  end

  assign o_port_data_lines = mode_test ? f_head[7:0] : (fwd_fifo ? out_r : data_r);
  assign o_port_data_lines_oe_n = dir_in;
  assign o_strobe_n = fwd_fifo ? !stb_r : !ctl_r[0];
  assign o_autofd_n = (mode_ecp && !dir_in) ? out_tag_r : !ctl_r[1];
  assign o_init_n = ctl_r[2];
  assign o_select_in_n = !ctl_r[3];

  always @* begin
    o_rdata = 8'h00;
    if (hit(i_addr, `ECPP_OFS_DATA)) begin
      o_rdata = (mode_spp || mode_bidir || mode_epp) ? pd_s2_r : 8'h00;
    end else if (hit(i_addr, `ECPP_OFS_STATUS)) begin
      o_rdata = {!busy_s, st_s2_r[3:0], 3'b111};
    end else if (hit(i_addr, `ECPP_OFS_CONTROL)) begin
      o_rdata = {2'b11, ctl_r};
    end else if (hit(i_addr, `ECPP_OFS_FIFO)) begin
      if (mode_cfg) begin
        o_rdata = `ECPP_CFGA_VALUE;
      end else if (fifo_win) begin
        o_rdata = f_head[7:0];
      end
    end else if (hit(i_addr, `ECPP_OFS_CFGB) && mode_cfg) begin
      o_rdata = {2'b00, 3'b000, cfgb_r};
    end else if (hit(i_addr, `ECPP_OFS_ECR)) begin
      o_rdata = ecr_r;
    end
  end
endmodule

/* sim/ecpp_core_properties.sv */
`timescale 1ns/10ps
module ecpp_core_properties #(parameter STROBE_CYC = 4) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire [10:0] i_addr,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] i_wdata,
  input wire [7:0] o_rdata,
  input wire [7:0] o_port_data_lines,
  input wire o_port_data_lines_oe_n,
  input wire o_strobe_n,
  input wire i_busy,
  input wire i_acknowledge_n,
  input wire i_paper_error,
  input wire i_select,
  input wire i_fault_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  reg [2:0] mode_r;
  reg [7:0] lo_cnt_r;
  reg [9:0] pin_r;
  wire [4:0] pins = {i_busy, i_acknowledge_n, i_paper_error, i_select, i_fault_n};
  // pins go through a two-stage sync, so only judge reads after three steady samples
  wire st_rd = i_rd && i_addr == 11'h001 && pin_r[4:0] == pins && pin_r[9:5] == pins;
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_r <= 3'h0;
      lo_cnt_r <= 8'h00;
      pin_r <= 10'h000;
    end else begin
      if (i_wr && i_addr == 11'h402)
        mode_r <= i_wdata[7:5];
      lo_cnt_r <= o_strobe_n ? 8'h00 : lo_cnt_r + 8'h01;
      pin_r <= {pin_r[4:0], pins};
    end
  end
  property p_st_fix; i_rd && i_addr == 11'h001 |-> o_rdata[2:0] == 3'h7; endproperty
  a_st_fix: assert property (p_st_fix) else $error("status low bits wrong");
  property p_st_busy; st_rd |-> o_rdata[7] == ~i_busy; endproperty
  a_st_busy: assert property (p_st_busy) else $error("status busy bit wrong");
  property p_st_pins; st_rd |-> o_rdata[6:3] == pins[3:0]; endproperty
  a_st_pins: assert property (p_st_pins) else $error("status pin bits wrong");
  property p_cfga; i_rd && i_addr == 11'h400 && mode_r == 3'h7 |-> o_rdata == 8'h10; endproperty
  a_cfga: assert property (p_cfga) else $error("config a value wrong");
  property p_ecr; i_rd && i_addr == 11'h402 |-> o_rdata[7:5] == mode_r; endproperty
  a_ecr: assert property (p_ecr) else $error("mode field wrong");
  property p_dout; mode_r == 3'h0 && i_wr && i_addr == 11'h000
    |=> o_port_data_lines == $past(i_wdata) && !o_port_data_lines_oe_n; endproperty
  a_dout: assert property (p_dout) else $error("data byte not driven");
  property p_dir; (mode_r == 3'h0 || mode_r == 3'h2) && $stable(mode_r) |-> !o_port_data_lines_oe_n; endproperty
  a_dir: assert property (p_dir) else $error("port not driven");
  property p_stb; mode_r == 3'h2 && $rose(o_strobe_n) |-> lo_cnt_r == STROBE_CYC; endproperty
  a_stb: assert property (p_stb) else $error("strobe width wrong");
  property p_rsvd; mode_r == 3'h5 && $stable(mode_r) |-> o_strobe_n; endproperty
  a_rsvd: assert property (p_rsvd) else $error("strobe in reserved mode");
endmodule

/* sim/ecpp_printer_model.sv */
`timescale 1ns/10ps
module ecpp_printer_model #(parameter ACK_NS = 40) (
  input wire i_strobe_n,
  output reg o_busy,
  output reg o_ack_n
);
  initial begin
    o_busy = 1'b0;
    o_ack_n = 1'b1;
  end
  always @(negedge i_strobe_n) o_busy <= #7 1'b1;
  // slow ack keeps busy up long enough to stall the next byte
  always @(posedge i_strobe_n) begin
    if (o_busy) begin
      #ACK_NS o_ack_n = 1'b0;
      #25 o_ack_n = 1'b1;
      o_busy = 1'b0;
    end
  end
endmodule

/* sim/ecp_parallel_port_core_tb_top.sv */
`timescale 1ns/10ps
module ecp_parallel_port_core_tb_top;
  reg i_clk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, busy_tb = 0, ack_tb = 1;
  reg i_paper_error = 0, i_select = 0, i_fault_n = 1;
  reg epp_en_tb = 0, dma_ack_tb = 0;
  reg [10:0] i_addr = 0;
  reg [7:0] i_wdata = 0, ext_d = 8'h3c, q;
  wire [7:0] o_rdata, o_pd;
  wire oe_n, stb_n, p_busy, p_ack, afd_n, init_n, slin_n, dreq;
  wire [7:0] pd = oe_n ? ext_d : o_pd;
  integer miscompares = 0, n_checks = 0, cyc = 0, k, w;
  reg [7:0] got[$];
  reg tag[$];
  always #2.5 i_clk = ~i_clk;
  always @(negedge stb_n) begin
    got.push_back(pd);
    tag.push_back(afd_n);
  end
  ecpp_core #(.STROBE_CYC(4)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr(i_wr),
    .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_epp_option_en(epp_en_tb), .i_dma_ack(dma_ack_tb),
    .o_dma_req(dreq), .i_port_data_lines(pd), .o_port_data_lines(o_pd), .o_port_data_lines_oe_n(oe_n),
    .o_strobe_n(stb_n), .o_autofd_n(afd_n), .o_init_n(init_n), .o_select_in_n(slin_n),
    .i_busy(p_busy | busy_tb),
    .i_acknowledge_n(p_ack & ack_tb), .i_paper_error(i_paper_error), .i_select(i_select),
    .i_fault_n(i_fault_n));
  ecpp_printer_model prn (.i_strobe_n(stb_n), .o_busy(p_busy), .o_ack_n(p_ack));
  task chk(input [7:0] s, input [7:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task wr(input [10:0] a, input [7:0] d);
    begin
      i_addr = a;
      i_wdata = d;
      i_wr = 1;
      @(negedge i_clk);
      i_wr = 0;
      @(negedge i_clk);
    end
  endtask
  task rd(input [10:0] a);
    begin
      i_addr = a;
      i_rd = 1;
      #2 q = o_rdata;
      @(negedge i_clk);
      i_rd = 0;
      @(negedge i_clk);
    end
  endtask
  task dma_pulse(input [7:0] d);
    begin
      i_wdata = d;
      dma_ack_tb = 1;
      @(negedge i_clk);
      dma_ack_tb = 0;
      @(negedge i_clk);
    end
  endtask
  task drain(input integer n);
    begin
      w = 0;
      while (got.size() < n && w < 3000) begin
        @(negedge i_clk);
        w = w + 1;
      end
      if (w == 3000) miscompares = miscompares + 1;
      repeat (40) @(negedge i_clk);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task t_status;
    for (k = 0; k < 32; k = k + 1) begin
      {busy_tb, ack_tb, i_paper_error, i_select, i_fault_n} = k[4:0];
      repeat (3) @(negedge i_clk);
      rd(11'h001);
      chk(q, {~k[4], k[3:0], 3'h7});
    end
  endtask
  task t_spp;
    begin
      wr(11'h002, 8'he0);
      chk({4'h0, afd_n, init_n, slin_n, oe_n}, 8'h0a);
      wr(11'h000, 8'ha5);
      chk(pd, 8'ha5);
      // read path sees the lines through a two-stage sync
      repeat (2) @(negedge i_clk);
      rd(11'h000);
      chk(q, 8'ha5);
      wr(11'h402, 8'h20);
      repeat (3) @(negedge i_clk);
      chk({7'h0, oe_n}, 8'h01);
      rd(11'h000);
      chk(q, 8'h3c);
      wr(11'h002, 8'hc0);
    end
  endtask
  task t_compat_fifo_window;
    begin
      wr(11'h402, 8'h40);
      busy_tb = 1;
      got.delete();
      for (k = 0; k < 18; k = k + 1) wr(11'h400, k[7:0] + 8'h10);
      rd(11'h402);
      chk({7'h0, q[1]}, 8'h01);
      busy_tb = 0;
      drain(17);
      chk(8'(got.size()), 8'd17);
      for (k = 0; k < 17; k = k + 1) chk(got[k], k[7:0] + 8'h10);
      rd(11'h402);
      chk({7'h0, q[0]}, 8'h01);
    end
  endtask
  task t_modes;
    begin
      wr(11'h402, 8'h60);
      got.delete();
      tag.delete();
      wr(11'h000, 8'h85);
      wr(11'h400, 8'h33);
      chk({7'h0, dreq}, 8'h01);
      dma_pulse(8'h4e);
      drain(3);
      chk(got[0], 8'h85);
      chk({7'h0, tag[0]}, 8'h01);
      chk(got[1], 8'h33);
      chk({7'h0, tag[1]}, 8'h00);
      chk(got[2], 8'h4e);
      wr(11'h402, 8'hc0);
      wr(11'h400, 8'h5a);
      wr(11'h400, 8'h69);
      rd(11'h400);
      chk(q, 8'h5a);
      rd(11'h400);
      chk(q, 8'h69);
      wr(11'h402, 8'he0);
      wr(11'h400, 8'hff);
      rd(11'h400);
      chk(q, 8'h10);
      rd(11'h401);
      chk({5'h0, q[2:0]}, 8'h07);
      wr(11'h402, 8'h80);
      rd(11'h000);
      chk(q, 8'h00);
      epp_en_tb = 1;
      rd(11'h000);
      chk(q, 8'ha5);
      epp_en_tb = 0;
      wr(11'h402, 8'ha0);
      got.delete();
      wr(11'h400, 8'h77);
      repeat (40) @(negedge i_clk);
      chk(8'(got.size()), 8'h00);
    end
  endtask
  task t_rev;
    begin
      wr(11'h402, 8'h60);
      wr(11'h002, 8'he0);
      // busy high with bit 7 clear marks a run-length count
      {busy_tb, ext_d, ack_tb} = {1'b1, 8'h02, 1'b0};
      repeat (4) @(negedge i_clk);
      ack_tb = 1;
      repeat (4) @(negedge i_clk);
      {busy_tb, ext_d, ack_tb} = {1'b0, 8'h9c, 1'b0};
      repeat (4) @(negedge i_clk);
      ack_tb = 1;
      repeat (12) @(negedge i_clk);
      chk({7'h0, dreq}, 8'h01);
      rd(11'h400);
      chk(q, 8'h9c);
      rd(11'h400);
      chk(q, 8'h9c);
      rd(11'h402);
      chk({7'h0, q[0]}, 8'h00);
      dma_pulse(8'h00);
      rd(11'h402);
      chk({7'h0, q[0]}, 8'h01);
      chk({7'h0, dreq}, 8'h00);
      ext_d = 8'h3c;
      wr(11'h002, 8'hc0);
    end
  endtask
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      tally_and_finish;
    end
  end
  initial begin
    repeat (3) @(negedge i_clk);
    i_sys_rst = 0;
    @(negedge i_clk);
    rd(11'h402);
    chk(q, 8'h15);
    rd(11'h002);
    chk(q, 8'hc0);
    t_status;
    t_spp;
    t_compat_fifo_window;
    t_modes;
    t_rev;
    tally_and_finish;
  end
endmodule
bind ecpp_core ecpp_core_properties #(.STROBE_CYC(STROBE_CYC)) u_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
  .o_port_data_lines(o_port_data_lines), .o_port_data_lines_oe_n(o_port_data_lines_oe_n),
  .o_strobe_n(o_strobe_n), .i_busy(i_busy), .i_acknowledge_n(i_acknowledge_n),
  .i_paper_error(i_paper_error), .i_select(i_select), .i_fault_n(i_fault_n));
